// file: hdl/sbfx_pkg.sv
// Constants for the store, bit and flag execution unit.
// Assumes an 8-bit core with 32 working registers and a flag byte.
package sbfx_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam logic [31:0] ADDR_CTRL    = 32'h0000_0000;
  localparam logic [31:0] ADDR_OPND    = 32'h0000_0004;
  localparam logic [31:0] ADDR_PTR     = 32'h0000_0008;
  localparam logic [31:0] ADDR_FLAGS   = 32'h0000_000c;
  localparam logic [31:0] ADDR_RESULT  = 32'h0000_0010;
  localparam logic [31:0] ADDR_STATUS  = 32'h0000_0014;
  localparam logic [31:0] ADDR_MEMDAT  = 32'h0000_0018;
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_T = 6;
  localparam int unsigned FLAG_I = 7;
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [15:0] PTR_RST   = 16'h0000;
  localparam logic [3:0]  CYC_ONE   = 4'h1;
  localparam logic [3:0]  CYC_TWO   = 4'h2;
  localparam logic [3:0]  CYC_THREE = 4'h3;
  // Operation codes written to the control register, low 5 bits
  localparam logic [4:0] OP_ST_PREDEC  = 5'h00;
  localparam logic [4:0] OP_ST_POSTINC = 5'h01;
  localparam logic [4:0] OP_ST_PLAIN   = 5'h02;
  localparam logic [4:0] OP_ST_DISP    = 5'h03;
  localparam logic [4:0] OP_ST_DIRECT  = 5'h04;
  localparam logic [4:0] OP_CODE_RD    = 5'h05;
  localparam logic [4:0] OP_CODE_RD_PI = 5'h06;
  localparam logic [4:0] OP_CODE_WR    = 5'h07;
  localparam logic [4:0] OP_PORT_IN    = 5'h08;
  localparam logic [4:0] OP_PORT_OUT   = 5'h09;
  localparam logic [4:0] OP_PUSH       = 5'h0a;
  localparam logic [4:0] OP_POP        = 5'h0b;
  localparam logic [4:0] OP_IO_RAISE   = 5'h0c;
  localparam logic [4:0] OP_IO_DROP    = 5'h0d;
  localparam logic [4:0] OP_SHL        = 5'h0e;
  localparam logic [4:0] OP_SHR        = 5'h0f;
  localparam logic [4:0] OP_ROL        = 5'h10;
  localparam logic [4:0] OP_ROR        = 5'h11;
  localparam logic [4:0] OP_ASR        = 5'h12;
  localparam logic [4:0] OP_SWAP       = 5'h13;
  localparam logic [4:0] OP_FLAG_SET   = 5'h14;
  localparam logic [4:0] OP_FLAG_CLR   = 5'h15;
  localparam logic [4:0] OP_BIT_TO_T   = 5'h16;
  localparam logic [4:0] OP_T_TO_BIT   = 5'h17;
  // Memory space selector on the memory port
  localparam logic [1:0] SP_DATA = 2'h0;
  localparam logic [1:0] SP_CODE = 2'h1;
  localparam logic [1:0] SP_IO   = 2'h2;
  typedef enum logic [1:0] {SBFX_IDLE, SBFX_RUN} sbfx_state_e;
endpackage

// file: hdl/sbfx_exec.sv
// Execution unit for stores, code-space access, port, stack, bit and flag operations.
// Assumes an APB master issues operations and a memory that answers within the same cycle.
// Function
// - Pre-decrement store: pointer minus one, then write; two cycles, no flags
// - Post-increment store: write at pointer, then pointer plus one; two cycles
// - Displaced store writes at pointer plus q; pointer kept; two cycles
// - Direct store writes at address k; two cycles, no flags
// - Code read at pointer into register, optional increment; three cycles
// - Push writes register to stack, pop reads stack; two cycles each
// - Pop loads stack byte in two cycles, flags untouched
// - I/O bit raise sets bit b, keeps others; two cycles
// - I/O bit drop clears bit b, keeps others; two cycles
// - Shift toward msb, zero in bit 0; one cycle; Z C N V
// - Shift toward lsb, zero in bit 7; one cycle; Z C N V
// - Rotate left through carry; one cycle; Z C N V
// - Rotate right through carry; one cycle; Z C N V
// - Signed shift right keeps bit 7; one cycle; Z C N V
// - Copy bit b to transfer flag; one cycle; only that flag
// - Transfer flag into bit b of register; one cycle; no flags
// - Sign flag raise and drop in one cycle, touching only it
// - One-cycle raise or drop of each flag alone
`timescale 1ns/10ps
`default_nettype none
module sbfx_exec
  import sbfx_pkg::*;
#(
  parameter int unsigned DATA_W = 8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             mem_we,
  output logic             mem_re,
  output logic      [1:0]  mem_space,
  output logic      [15:0] mem_addr,
  output logic      [15:0] mem_wdata,
  input  wire logic [7:0]  mem_rdata
);
  // Only the byte-wide data path is built
  if (DATA_W != 8) begin : g_width_check
    $error("sbfx_exec serves only 8-bit data");
  end

  // Software-visible state and internal sequencer state
  logic [4:0]  op;
  logic [7:0]  opnd_a;
  logic [7:0]  opnd_b;
  logic [5:0]  disp;
  logic [2:0]  bsel;
  logic [15:0] ptr;
  logic [15:0] dir_addr;
  logic [7:0]  flags;
  logic [7:0]  result;
  logic        busy;
  logic        done;
  logic [3:0]  cyc;
  logic [3:0]  cyc_need;
  logic [15:0] sp;
  sbfx_state_e state;

  wire acc      = psel && penable;
  wire wr_acc   = acc && pwrite;
  wire hit_ctrl = paddr == ADDR_CTRL;
  wire hit_opnd = paddr == ADDR_OPND;
  wire hit_ptr  = paddr == ADDR_PTR;
  wire hit_flg  = paddr == ADDR_FLAGS;
  wire hit_res  = paddr == ADDR_RESULT;
  wire hit_st   = paddr == ADDR_STATUS;
  wire hit_mem  = paddr == ADDR_MEMDAT;
  wire mapped   = hit_ctrl | hit_opnd | hit_ptr | hit_flg | hit_res | hit_st | hit_mem;
  wire start    = wr_acc && hit_ctrl && !busy;
  // Register writes land at the access edge and are refused while an operation runs
  wire wr_ok    = wr_acc && pready && !busy;
  wire wr_opnd  = wr_ok && hit_opnd;
  wire wr_ptr   = wr_ok && hit_ptr;
  wire wr_flg   = wr_ok && hit_flg;
  wire go       = start && pready;

  // Cycle budget per operation
  wire [4:0] op_new = pwdata[4:0];
  wire is_two   = op_new <= OP_ST_DIRECT || (op_new >= OP_PUSH && op_new <= OP_IO_DROP);
  wire is_three = op_new == OP_CODE_RD || op_new == OP_CODE_RD_PI || op_new == OP_CODE_WR;
  wire [3:0] next_need = is_three ? CYC_THREE : (is_two ? CYC_TWO : CYC_ONE);

  // Single-cycle data path
  wire [7:0] shl_v  = {opnd_a[6:0], 1'b0};
  wire [7:0] shr_v  = {1'b0, opnd_a[7:1]};
  wire [7:0] rol_v  = {opnd_a[6:0], flags[FLAG_C]};
  wire [7:0] ror_v  = {flags[FLAG_C], opnd_a[7:1]};
  wire [7:0] asr_v  = {opnd_a[7], opnd_a[7:1]};
  wire [7:0] swap_v = {opnd_a[3:0], opnd_a[7:4]};
  wire [7:0] bmask  = 8'h01 << bsel;
  wire [7:0] tbit_v = flags[FLAG_T] ? (opnd_a | bmask) : (opnd_a & ~bmask);
  wire is_left  = op == OP_SHL || op == OP_ROL;
  wire is_shift = op >= OP_SHL && op <= OP_ASR;
  wire [7:0] sh_v = op == OP_SHL ? shl_v : op == OP_SHR ? shr_v :
                    op == OP_ROL ? rol_v : op == OP_ROR ? ror_v : asr_v;
  wire sh_c = is_left ? opnd_a[7] : opnd_a[0];
  wire sh_n = sh_v[7];
  wire sh_v_flag = sh_n ^ sh_c;
  wire [7:0] sh_flags = {flags[7:4], sh_v_flag, sh_n, sh_v == 8'h00, sh_c};

  wire [15:0] ptr_dec  = ptr - 16'h0001;
  wire [15:0] ptr_inc  = ptr + 16'h0001;
  wire [15:0] disp_adr = ptr + {10'h000, disp};
  wire [15:0] sp_dec   = sp - 16'h0001;
  wire [15:0] sp_inc   = sp + 16'h0001;
  wire last = cyc == cyc_need;
  wire act  = state == SBFX_RUN;
  wire fin  = act && last;
  wire [3:0] next_cyc = cyc + CYC_ONE;

  // Flag byte effect of the operation in flight
  logic [7:0] next_flags;
  always_comb begin
    next_flags = flags;
    if (act && last) begin
      unique case (op)
        OP_SHL, OP_SHR, OP_ROL, OP_ROR, OP_ASR: next_flags = sh_flags;
        OP_FLAG_SET: next_flags[bsel] = 1'b1;
        OP_FLAG_CLR: next_flags[bsel] = 1'b0;
        OP_BIT_TO_T: next_flags[FLAG_T] = opnd_a[bsel];
        default: next_flags = flags;
      endcase
    end
  end

  // Memory request of each memory operation, set up in its final cycle and registered onto the port one cycle later
  logic        next_we;
  logic        next_re;
  logic [1:0]  next_space;
  logic [15:0] next_addr;
  logic [15:0] next_wdata;
  always_comb begin
    next_we    = 1'b0;
    next_re    = 1'b0;
    next_space = SP_DATA;
    next_addr  = 16'h0000;
    next_wdata = {8'h00, opnd_a};
    if (act && last) begin
      unique case (op)
        OP_ST_PREDEC: begin
          next_we   = 1'b1;
          next_addr = ptr_dec;
        end
        OP_ST_POSTINC, OP_ST_PLAIN: begin
          next_we   = 1'b1;
          next_addr = ptr;
        end
        OP_ST_DISP: begin
          next_we   = 1'b1;
          next_addr = disp_adr;
        end
        OP_ST_DIRECT: begin
          next_we   = 1'b1;
          next_addr = dir_addr;
        end
        OP_CODE_RD, OP_CODE_RD_PI: begin
          next_re    = 1'b1;
          next_space = SP_CODE;
          next_addr  = ptr;
        end
        OP_CODE_WR: begin
          next_we    = 1'b1;
          next_space = SP_CODE;
          next_addr  = ptr;
          next_wdata = {opnd_b, opnd_a};
        end
        OP_PORT_IN: begin
          next_re    = 1'b1;
          next_space = SP_IO;
          next_addr  = dir_addr;
        end
        OP_PORT_OUT: begin
          next_we    = 1'b1;
          next_space = SP_IO;
          next_addr  = dir_addr;
        end
        OP_PUSH: begin
          next_we   = 1'b1;
          next_addr = sp;
        end
        OP_POP: begin
          next_re   = 1'b1;
          next_addr = sp_inc;
        end
        OP_IO_RAISE, OP_IO_DROP: begin
          next_we    = 1'b1;
          next_space = SP_IO;
          next_addr  = dir_addr;
          next_wdata = {8'h00, op == OP_IO_RAISE ? (opnd_a | bmask) : (opnd_a & ~bmask)};
        end
        default: next_we = 1'b0;
      endcase
    end
  end

  // Read data only stands once the registered address is out, so it is taken while mem_re is high
  wire reads_mem = mem_re;
  wire [7:0] next_result = reads_mem ? mem_rdata :
                           (fin && is_shift) ? sh_v :
                           (fin && op == OP_SWAP) ? swap_v :
                           (fin && op == OP_T_TO_BIT) ? tbit_v : result;

  // Register read mux
  wire [31:0] ctrl_word = {27'h0, op};
  wire [31:0] opnd_word = {7'h00, bsel, disp, opnd_b, opnd_a};
  wire [31:0] ptr_word  = {dir_addr, ptr};
  wire [31:0] flg_word  = {24'h0, flags};
  wire [31:0] res_word  = {24'h0, result};
  wire [31:0] stat_word = {sp, 14'h0, done, busy};
  wire [31:0] mem_word  = {24'h0, mem_rdata};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_word :
                       hit_opnd ? opnd_word :
                       hit_ptr  ? ptr_word :
                       hit_flg  ? flg_word :
                       hit_res  ? res_word :
                       hit_st   ? stat_word :
                       hit_mem  ? mem_word : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= psel && !pready;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= psel && !pready && !mapped;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0;
    else
      prdata <= (psel && !pwrite) ? rd_mux : 32'h0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opnd_a <= 8'h00;
      opnd_b <= 8'h00;
      disp   <= 6'h00;
      bsel   <= 3'h0;
    end else if (wr_opnd) begin
      opnd_a <= pwdata[7:0];
      opnd_b <= pwdata[15:8];
      disp   <= pwdata[21:16];
      bsel   <= pwdata[24:22];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      dir_addr <= 16'h0000;
    else if (wr_ptr)
      dir_addr <= pwdata[31:16];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      op <= OP_ST_PLAIN;
    else if (go)
      op <= op_new;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= SBFX_IDLE;
      cyc      <= 4'h0;
      cyc_need <= CYC_ONE;
      busy     <= 1'b0;
      done     <= 1'b0;
    end else begin
      unique case (state)
        SBFX_IDLE: begin
          if (go) begin
            state    <= SBFX_RUN;
            cyc      <= CYC_ONE;
            cyc_need <= next_need;
            busy     <= 1'b1;
            done     <= 1'b0;
          end
        end
        SBFX_RUN: begin
          cyc <= next_cyc;
          if (last) begin
            state <= SBFX_IDLE;
            busy  <= 1'b0;
            done  <= 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      flags <= FLAGS_RST;
    else
      flags <= wr_flg ? pwdata[7:0] : next_flags;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      result <= 8'h00;
    else
      result <= next_result;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ptr <= PTR_RST;
    else if (wr_ptr)
      ptr <= pwdata[15:0];
    else if (fin && op == OP_ST_PREDEC)
      ptr <= ptr_dec;
    else if (fin && (op == OP_ST_POSTINC || op == OP_CODE_RD_PI))
      ptr <= ptr_inc;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      sp <= 16'hffff;
    else if (fin && op == OP_PUSH)
      sp <= sp_dec;
    else if (fin && op == OP_POP)
      sp <= sp_inc;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      mem_we <= 1'b0;
    else
      mem_we <= next_we;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      mem_re <= 1'b0;
    else
      mem_re <= next_re;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      mem_space <= SP_DATA;
    else
      mem_space <= next_space;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      mem_addr <= 16'h0000;
    else
      mem_addr <= next_addr;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      mem_wdata <= 16'h0000;
    else
      mem_wdata <= next_wdata;
  end
endmodule
`default_nettype wire

// file: bench/sbfx_exec_sva.sv
// Checker for the execution unit's bus and memory port timing.
// Assumes it is bound onto sbfx_exec with one clock, pclk.
`timescale 1ns/10ps
`default_nettype none
module sbfx_exec_chk
  import sbfx_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        mem_we,
  input wire logic        mem_re,
  input wire logic [1:0]  mem_space
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic       ctl_wr;
  wire logic [4:0] op;
  assign ctl_wr = psel && penable && pready && pwrite && paddr == ADDR_CTRL;
  assign op     = pwdata[4:0];
  property p_dir; ctl_wr && op == OP_ST_DIRECT |-> ##3 mem_we && mem_space == SP_DATA; endproperty
  a_dir: assert property (p_dir) else $error("direct store write missing");
  property p_push; ctl_wr && op == OP_PUSH |-> ##3 mem_we && mem_space == SP_DATA; endproperty
  a_push: assert property (p_push) else $error("push write missing");
  property p_pop; ctl_wr && op == OP_POP |-> ##3 mem_re && mem_space == SP_DATA; endproperty
  a_pop: assert property (p_pop) else $error("pop read missing");
  property p_code; ctl_wr && op == OP_CODE_RD |-> ##4 mem_re && mem_space == SP_CODE; endproperty
  a_code: assert property (p_code) else $error("code read missing");
  property p_io; ctl_wr && op == OP_IO_RAISE |-> ##3 mem_we && mem_space == SP_IO; endproperty
  a_io: assert property (p_io) else $error("io bit write missing");
  property p_out; ctl_wr && op == OP_PORT_OUT |-> ##2 mem_we && mem_space == SP_IO; endproperty
  a_out: assert property (p_out) else $error("port write missing");
  property p_flag; ctl_wr && op == OP_FLAG_SET |-> !(mem_we || mem_re) [*4]; endproperty
  a_flag: assert property (p_flag) else $error("flag op touched memory");
  property p_we; mem_we |=> !mem_we && !$past(mem_re); endproperty
  a_we: assert property (p_we) else $error("write pulse too long");
endmodule
bind sbfx_exec sbfx_exec_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .mem_we(mem_we), .mem_re(mem_re),
  .mem_space(mem_space));
`default_nettype wire

// file: bench/sbfx_mem_model.sv
// Data, code and I/O memory behind the execution unit.
// Assumes reads are answered from the current address without delay.
`timescale 1ns/10ps
`default_nettype none
module sbfx_mem_model (
  input wire logic        pclk,
  input wire logic        mem_we,
  input wire logic [1:0]  mem_space,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic     [7:0]  mem_rdata
);
  logic [7:0]  mem [logic [17:0]];
  logic [1:0]  lw_sp = 2'h3;
  logic [15:0] lw_a  = 16'h0;
  logic [15:0] lw_d  = 16'h0;
  // Unwritten places read as a pattern of their address
  always @* begin
    if (mem.exists({mem_space, mem_addr})) mem_rdata = mem[{mem_space, mem_addr}];
    else mem_rdata = mem_addr[7:0] ^ 8'ha5;
  end
  always @(posedge pclk) begin
    if (mem_we === 1'b1) begin
      mem[{mem_space, mem_addr}] = mem_wdata[7:0];
      lw_sp = mem_space;
      lw_a  = mem_addr;
      lw_d  = mem_wdata;
    end
  end
endmodule
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the execution unit over APB.
// Assumes the memory model answers every memory access.
`timescale 1ns/10ps
`default_nettype none
module testbench
  import sbfx_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, we, re, er;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic [1:0]  sp;
  logic [15:0] ma, mw;
  logic [7:0]  mr;
  int n_mismatch = 0, comparisons = 0;
  always #25 pclk = ~pclk;
  sbfx_exec u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_we(we),
    .mem_re(re), .mem_space(sp), .mem_addr(ma), .mem_wdata(mw), .mem_rdata(mr));
  sbfx_mem_model m (.pclk(pclk), .mem_we(we), .mem_space(sp), .mem_addr(ma), .mem_wdata(mw), .mem_rdata(mr));
  task automatic end_sim;
    if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, d);
    int i;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdc(input logic [31:0] a, e);
    apb(0, a, 0);
    chk(rd, e);
  endtask
  task automatic setr(input logic [31:0] o, p, f);
    apb(1, ADDR_OPND, o);
    apb(1, ADDR_PTR, p);
    apb(1, ADDR_FLAGS, f);
  endtask
  task automatic run(input logic [4:0] op);
    int i;
    apb(1, ADDR_CTRL, {27'h0, op});
    i = 0;
    do begin
      apb(0, ADDR_STATUS, 0);
      i++;
    end while (rd[0] !== 1'b0 && i < 20);
    if (rd[0] !== 1'b0) begin
      n_mismatch++;
      end_sim();
    end
  endtask
  task automatic wchk(input logic [1:0] s, input logic [15:0] a, d);
    chk({m.lw_sp, m.lw_a, m.lw_d}, {s, a, d});
  endtask
  task automatic s_stores;
    setr(32'h0003_005a, 32'h0200_0010, 0);
    run(OP_ST_PREDEC);
    wchk(SP_DATA, 16'h000f, 16'h005a);
    rdc(ADDR_PTR, 32'h0200_000f);
    run(OP_ST_POSTINC);
    wchk(SP_DATA, 16'h000f, 16'h005a);
    rdc(ADDR_PTR, 32'h0200_0010);
    run(OP_ST_DISP);
    wchk(SP_DATA, 16'h0013, 16'h005a);
    rdc(ADDR_PTR, 32'h0200_0010);
    run(OP_ST_DIRECT);
    wchk(SP_DATA, 16'h0200, 16'h005a);
    rdc(ADDR_FLAGS, 0);
  endtask
  task automatic s_code;
    setr(32'h1122, 32'h40, 0);
    run(OP_CODE_WR);
    wchk(SP_CODE, 16'h0040, 16'h1122);
    run(OP_CODE_RD);
    rdc(ADDR_RESULT, 32'h22);
    run(OP_CODE_RD_PI);
    rdc(ADDR_PTR, 32'h41);
    run(OP_CODE_RD);
    rdc(ADDR_RESULT, 32'he4);
  endtask
  task automatic s_stack;
    setr(32'h33, 0, 32'h0f);
    run(OP_PUSH);
    wchk(SP_DATA, 16'hffff, 16'h0033);
    apb(0, ADDR_STATUS, 0);
    chk({16'h0, rd[31:16]}, 32'h0000_fffe);
    setr(0, 0, 32'h0f);
    run(OP_POP);
    rdc(ADDR_RESULT, 32'h33);
    rdc(ADDR_FLAGS, 32'h0f);
  endtask
  task automatic s_io;
    setr(32'h00c0_0080, 32'h001f_0000, 0);
    run(OP_IO_RAISE);
    wchk(SP_IO, 16'h001f, 16'h0088);
    setr(32'h01c0_0088, 32'h001f_0000, 0);
    run(OP_IO_DROP);
    wchk(SP_IO, 16'h001f, 16'h0008);
    setr(32'h3c, 32'h001f_0000, 0);
    run(OP_PORT_OUT);
    wchk(SP_IO, 16'h001f, 16'h003c);
    run(OP_PORT_IN);
    rdc(ADDR_RESULT, 32'h3c);
  endtask
  task automatic s_shift;
    logic [4:0] ops [6] = '{OP_SHL, OP_SHR, OP_ROL, OP_ROR, OP_ASR, OP_SWAP};
    logic [7:0] res [6] = '{8'h02, 8'h40, 8'h03, 8'hc0, 8'hc0, 8'h18};
    logic [7:0] fl [6]  = '{8'h09, 8'h09, 8'h09, 8'h05, 8'h05, 8'h01};
    for (int i = 0; i < 6; i++) begin
      setr(32'h81, 0, 32'h01);
      run(ops[i]);
      rdc(ADDR_RESULT, {24'h0, res[i]});
      rdc(ADDR_FLAGS, {24'h0, fl[i]});
    end
  endtask
  task automatic s_flags;
    for (int i = 0; i < 8; i++) begin
      setr(i << 22, 0, 0);
      run(OP_FLAG_SET);
      rdc(ADDR_FLAGS, 32'h1 << i);
      setr(i << 22, 0, 32'hff);
      run(OP_FLAG_CLR);
      rdc(ADDR_FLAGS, 32'hff ^ (32'h1 << i));
    end
    setr(32'h0080_0004, 0, 0);
    run(OP_BIT_TO_T);
    rdc(ADDR_FLAGS, 32'h40);
    setr(32'h0140_0000, 0, 32'h40);
    run(OP_T_TO_BIT);
    rdc(ADDR_RESULT, 32'h20);
    rdc(ADDR_FLAGS, 32'h40);
    rdc(32'h40, 0);
    chk({31'h0, er}, 1);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    rdc(ADDR_FLAGS, 0);
    s_stores();
    s_code();
    s_stack();
    s_io();
    s_shift();
    s_flags();
    end_sim();
  end
endmodule
`default_nettype wire
